// File: include/tap_relay_consts.vh
`ifndef TAP_RELAY_CONSTS_VH
`define TAP_RELAY_CONSTS_VH

// Register word indices (address bits 5:2)
`define OFS_CTRL        4'h0
`define OFS_NOMINAL     4'h1
`define OFS_LOWER_PCT   4'h2
`define OFS_RAISE_PCT   4'h3
`define OFS_UV_PCT      4'h4
`define OFS_OV_PCT      4'h5
`define OFS_T1          4'h6
`define OFS_CUR_LIMIT   4'h7
`define OFS_STATUS      4'h8
`define OFS_IRQ_STATUS  4'h9
`define OFS_IRQ_MASK    4'ha
`define OFS_VOLTAGE     4'hb

// Control fields
`define CTRL_MANUAL     0
`define CTRL_OC_EN      1
`define CTRL_UNIT_LO    2
`define CTRL_UNIT_HI    3
`define UNIT_VOLTS      2'h0
`define UNIT_KV         2'h1
`define UNIT_PCT        2'h2
`define UNIT_SEC        2'h3

// Reset values (voltage in 0.1 V, percentages in 0.1 %)
`define RST_NOMINAL     16'h044c
`define RST_LOWER_PCT   11'h014
`define RST_RAISE_PCT   11'h014
`define RST_UV_PCT      11'h320
`define RST_OV_PCT      11'h44c
`define RST_T1          8'h1e
`define RST_CUR_LIMIT   16'h03e8

// Scaling in tenths of a percent
`define PCT_FULL        11'h3e8
`define HYST_PCT        11'h032
`define SHED3_PCT       11'h01e
`define SHED6_PCT       11'h03c
`define SHED9_PCT       11'h05a

// Timing
`define CLK_HZ          100000000
`define CF_DELAY_S      9'h12c
`define PULSE_S         8'h02
`define HSR_S           8'h02

// Interrupt bits
`define IRQ_UV          0
`define IRQ_OV          1
`define IRQ_CF          2
`define IRQ_LOWER       3
`define IRQ_RAISE       4

// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: rtl/tap_relay.v
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "tap_relay_consts.vh"

module tap_relay #(
    parameter TICK_CYCLES = `CLK_HZ
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [5:0]  awaddr,
    input  wire        awvalid,
    output reg         awready,
    // AXI4-Lite write data
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // AXI4-Lite write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // AXI4-Lite read
    input  wire [5:0]  araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // Measurements
    input  wire [15:0] meas_voltage,
    input  wire        meas_valid,
    input  wire [15:0] meas_current,
    // Loadshedding contacts, high while closed
    input  wire        shed_three_pct_input,
    input  wire        shed_six_pct_input,
    input  wire        shed_nine_pct_input,
    // Relay drives
    output reg         lower_relay,
    output reg         raise_relay,
    output reg         uv_relay,
    output reg         ov_relay,
    output reg         control_fail_relay,
    // Lamps
    output reg         lower_presignal_lamp,
    output reg         raise_presignal_lamp,
    output reg         uv_lamp,
    output reg         ov_lamp,
    output reg         lower_relay_lamp,
    output reg         raise_relay_lamp,
    output reg         manual_lamp,
    output reg         control_fail_lamp,
    output reg         volts_lamp,
    output reg         kv_lamp,
    output reg         pct_lamp,
    output reg         sec_lamp,
    output reg         shed3_lamp,
    output reg         shed6_lamp,
    output reg         shed9_lamp,
    // Interrupt
    output reg         irq
);

    localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
    localparam [26:0] TICK_LAST = TICK_FULL[26:0];
    localparam [2:0]  ST_IDLE    = 3'h0;
    localparam [2:0]  ST_DELAY   = 3'h1;
    localparam [2:0]  ST_PULSE   = 3'h2;
    localparam [2:0]  ST_HSR_ON  = 3'h3;
    localparam [2:0]  ST_HSR_OFF = 3'h4;

    // --------------------------------------------------------------
    // Software registers
    // --------------------------------------------------------------
    reg [3:0]  ctrl_reg;
    reg [15:0] nominal_reg;
    reg [10:0] lower_pct_reg;
    reg [10:0] raise_pct_reg;
    reg [10:0] uv_pct_reg;
    reg [10:0] ov_pct_reg;
    reg [7:0]  t1_reg;
    reg [15:0] cur_limit_reg;
    reg [4:0]  irq_status_reg;
    reg [4:0]  irq_mask_reg;
    reg        aw_have_reg;
    reg        w_have_reg;
    reg [3:0]  aw_idx_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;

    // --------------------------------------------------------------
    // Measurement and control state
    // --------------------------------------------------------------
    reg [15:0] sample_reg;
    reg        valid_reg;
    reg        uv_reg;
    reg        ov_reg;
    reg        cf_reg;
    reg [8:0]  cf_sec_reg;
    reg [26:0] tick_cnt_reg;
    reg        tick_reg;
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg        dir_lower_reg;
    reg        dir_lower_next;
    reg [7:0]  sec_cnt_reg;
    reg [7:0]  sec_cnt_next;
    reg        lower_relay_next;
    reg        raise_relay_next;
    wire       lower_pre;
    wire       raise_pre;
    wire       oc_block;

    // Scale a voltage by a figure in tenths of a percent
    function [15:0] scale;
        input [15:0] volts;
        input [10:0] pct;
        reg   [26:0] prod;
        begin
            prod  = volts * pct;
            prod  = prod / `PCT_FULL;
            scale = prod[15:0];
        end
    endfunction

    // Merge bus write data into a word under the byte strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Register read view, shared by reads and strobed writes
    function [31:0] reg_word;
        input [3:0] idx;
        begin
            case (idx)
                `OFS_CTRL:       reg_word = {28'h0, ctrl_reg};
                `OFS_NOMINAL:    reg_word = {16'h0, nominal_reg};
                `OFS_LOWER_PCT:  reg_word = {21'h0, lower_pct_reg};
                `OFS_RAISE_PCT:  reg_word = {21'h0, raise_pct_reg};
                `OFS_UV_PCT:     reg_word = {21'h0, uv_pct_reg};
                `OFS_OV_PCT:     reg_word = {21'h0, ov_pct_reg};
                `OFS_T1:         reg_word = {24'h0, t1_reg};
                `OFS_CUR_LIMIT:  reg_word = {16'h0, cur_limit_reg};
                `OFS_STATUS:     reg_word = {22'h0, valid_reg, oc_block, ov_reg, uv_reg, cf_reg,
                                             raise_relay, lower_relay, raise_pre, lower_pre, state_reg == ST_HSR_ON};
                `OFS_IRQ_STATUS: reg_word = {27'h0, irq_status_reg};
                `OFS_IRQ_MASK:   reg_word = {27'h0, irq_mask_reg};
                `OFS_VOLTAGE:    reg_word = {16'h0, sample_reg};
                default:         reg_word = 32'h0;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // Limits from the shed-reduced setpoint
    // --------------------------------------------------------------
    wire [10:0] shed_pct = shed9_lamp ? `SHED9_PCT : shed6_lamp ? `SHED6_PCT :
                           shed3_lamp ? `SHED3_PCT : 11'h0;
    // The deepest active step wins if several contacts close at once
    wire [15:0] eff_nom  = scale(nominal_reg, `PCT_FULL - shed_pct);
    wire [15:0] lower_lim = scale(eff_nom, `PCT_FULL + lower_pct_reg);
    wire [15:0] raise_lim = scale(eff_nom, `PCT_FULL - raise_pct_reg);
    wire [15:0] uv_lim    = scale(eff_nom, uv_pct_reg);
    wire [15:0] uv_rest   = scale(eff_nom, uv_pct_reg + `HYST_PCT);
    wire [15:0] ov_lim    = scale(eff_nom, ov_pct_reg);
    wire [15:0] ov_rest   = scale(eff_nom, ov_pct_reg - `HYST_PCT);

    // Every comparison reads the one held sample
    assign lower_pre = valid_reg & (sample_reg > lower_lim);
    assign raise_pre = valid_reg & (sample_reg < raise_lim);
    wire uv_next = ~valid_reg ? 1'b0 : (sample_reg < uv_lim) ? 1'b1 :
                   (sample_reg > uv_rest) ? 1'b0 : uv_reg;
    wire ov_next = ~valid_reg ? 1'b0 : (sample_reg > ov_lim) ? 1'b1 :
                   (sample_reg < ov_rest) ? 1'b0 : ov_reg;

    // Overcurrent: current above 3/2 of the load limit
    assign oc_block = ctrl_reg[`CTRL_OC_EN] &
                    ({1'b0, meas_current, 1'b0} > ({2'h0, cur_limit_reg} + {1'b0, cur_limit_reg, 1'b0}));
    wire manual    = ctrl_reg[`CTRL_MANUAL];
    wire lower_ok  = ~manual & ~oc_block;
    wire raise_ok  = ~manual & ~oc_block & ~uv_reg & ~cf_reg;
    wire blocked   = dir_lower_reg ? ~lower_ok : ~raise_ok;
    wire dev_here  = dir_lower_reg ? lower_pre : raise_pre;

    // --------------------------------------------------------------
    // Tap command sequencer
    // --------------------------------------------------------------
    // Manual or overcurrent aborts a pulse at once rather than letting it finish
    always @* begin
        state_next     = state_reg;
        dir_lower_next = dir_lower_reg;
        sec_cnt_next   = sec_cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                sec_cnt_next = 8'h0;
                if (ov_reg && lower_ok) begin
                    state_next     = ST_HSR_ON;
                    dir_lower_next = 1'b1;
                end else if (lower_pre && lower_ok) begin
                    state_next     = ST_DELAY;
                    dir_lower_next = 1'b1;
                end else if (raise_pre && raise_ok) begin
                    state_next     = ST_DELAY;
                    dir_lower_next = 1'b0;
                end
            end
            ST_DELAY: begin
                if (ov_reg || !dev_here || blocked) begin
                    state_next = ST_IDLE;
                end else if (tick_reg) begin
                    sec_cnt_next = sec_cnt_reg + 8'h1;
                    if (sec_cnt_next >= t1_reg) begin
                        state_next   = ST_PULSE;
                        sec_cnt_next = 8'h0;
                    end
                end
            end
            ST_PULSE: begin
                if (blocked) begin
                    state_next = ST_IDLE;
                end else if (tick_reg) begin
                    sec_cnt_next = sec_cnt_reg + 8'h1;
                    if (sec_cnt_next == `PULSE_S) begin
                        state_next   = ST_DELAY;
                        sec_cnt_next = 8'h0;
                    end
                end
            end
            ST_HSR_ON, ST_HSR_OFF: begin
                if (!ov_reg || !lower_ok) begin
                    state_next = ST_IDLE;
                end else if (tick_reg) begin
                    sec_cnt_next = sec_cnt_reg + 8'h1;
                    if (sec_cnt_next == `HSR_S) begin
                        state_next   = (state_reg == ST_HSR_ON) ? ST_HSR_OFF : ST_HSR_ON;
                        sec_cnt_next = 8'h0;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        lower_relay_next = (state_next == ST_HSR_ON) | ((state_next == ST_PULSE) & dir_lower_next);
        raise_relay_next = (state_next == ST_PULSE) & ~dir_lower_next;
    end

    // --------------------------------------------------------------
    // Timing, measurement and outputs
    // --------------------------------------------------------------
    // One-second tick and control-fail timer
    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_reg  <= 27'h0;
            tick_reg      <= 1'b0;
            cf_sec_reg    <= 9'h0;
            cf_reg        <= 1'b0;
            state_reg     <= ST_IDLE;
            dir_lower_reg <= 1'b0;
            sec_cnt_reg   <= 8'h0;
        end else begin
            tick_reg      <= (tick_cnt_reg == TICK_LAST);
            tick_cnt_reg  <= (tick_cnt_reg == TICK_LAST) ? 27'h0 : tick_cnt_reg + 27'h1;
            state_reg     <= state_next;
            dir_lower_reg <= dir_lower_next;
            sec_cnt_reg   <= sec_cnt_next;
            if (!(lower_pre || raise_pre)) begin
                cf_sec_reg <= 9'h0;
                cf_reg     <= 1'b0;
            end else if (tick_reg) begin
                if (cf_sec_reg == `CF_DELAY_S) begin
                    cf_reg <= 1'b1;
                end else begin
                    cf_sec_reg <= cf_sec_reg + 9'h1;
                end
            end
        end
    end

    // Sample capture, relays and lamps
    always @(posedge aclk) begin
        if (!aresetn) begin
            sample_reg           <= 16'h0;
            valid_reg            <= 1'b0;
            uv_reg               <= 1'b0;
            ov_reg               <= 1'b0;
            lower_relay          <= 1'b0;
            raise_relay          <= 1'b0;
            uv_relay             <= 1'b0;
            ov_relay             <= 1'b0;
            control_fail_relay   <= 1'b0;
            lower_presignal_lamp <= 1'b0;
            raise_presignal_lamp <= 1'b0;
            uv_lamp              <= 1'b0;
            ov_lamp              <= 1'b0;
            lower_relay_lamp     <= 1'b0;
            raise_relay_lamp     <= 1'b0;
            manual_lamp          <= 1'b0;
            control_fail_lamp    <= 1'b0;
            volts_lamp           <= 1'b0;
            kv_lamp              <= 1'b0;
            pct_lamp             <= 1'b0;
            sec_lamp             <= 1'b0;
            shed3_lamp           <= 1'b0;
            shed6_lamp           <= 1'b0;
            shed9_lamp           <= 1'b0;
        end else begin
            if (meas_valid) begin
                sample_reg <= meas_voltage;
                valid_reg  <= 1'b1;
            end
            uv_reg               <= uv_next;
            ov_reg               <= ov_next;
            uv_relay             <= uv_next;
            uv_lamp              <= uv_next;
            ov_relay             <= ov_next;
            ov_lamp              <= ov_next;
            lower_presignal_lamp <= lower_pre;
            raise_presignal_lamp <= raise_pre;
            lower_relay          <= lower_relay_next;
            lower_relay_lamp     <= lower_relay_next;
            raise_relay          <= raise_relay_next;
            raise_relay_lamp     <= raise_relay_next;
            control_fail_relay   <= cf_reg;
            control_fail_lamp    <= cf_reg;
            manual_lamp          <= manual;
            volts_lamp <= (ctrl_reg[`CTRL_UNIT_HI:`CTRL_UNIT_LO] == `UNIT_VOLTS);
            kv_lamp    <= (ctrl_reg[`CTRL_UNIT_HI:`CTRL_UNIT_LO] == `UNIT_KV);
            pct_lamp   <= (ctrl_reg[`CTRL_UNIT_HI:`CTRL_UNIT_LO] == `UNIT_PCT);
            sec_lamp   <= (ctrl_reg[`CTRL_UNIT_HI:`CTRL_UNIT_LO] == `UNIT_SEC);
            shed3_lamp <= shed_three_pct_input;
            shed6_lamp <= shed_six_pct_input;
            shed9_lamp <= shed_nine_pct_input;
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite slave and interrupt
    // --------------------------------------------------------------
    wire        do_write = aw_have_reg & w_have_reg & ~bvalid;
    wire        rd_take  = arvalid & arready;
    wire        wr_ok    = (aw_idx_reg <= `OFS_VOLTAGE);
    wire [31:0] wr_word  = merge(reg_word(aw_idx_reg), wdata_reg, wstrb_reg);
    wire [4:0]  irq_set  = {raise_relay_next & ~raise_relay, lower_relay_next & ~lower_relay,
                            cf_reg & ~control_fail_relay, ov_next & ~ov_reg, uv_next & ~uv_reg};

    // Address and data are held separately so either may arrive first
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready        <= 1'b1;
            wready         <= 1'b1;
            bvalid         <= 1'b0;
            bresp          <= `RESP_OKAY;
            arready        <= 1'b1;
            rvalid         <= 1'b0;
            rdata          <= 32'h0;
            rresp          <= `RESP_OKAY;
            aw_have_reg    <= 1'b0;
            w_have_reg     <= 1'b0;
            aw_idx_reg     <= 4'h0;
            wdata_reg      <= 32'h0;
            wstrb_reg      <= 4'h0;
            ctrl_reg       <= 4'h0;
            nominal_reg    <= `RST_NOMINAL;
            lower_pct_reg  <= `RST_LOWER_PCT;
            raise_pct_reg  <= `RST_RAISE_PCT;
            uv_pct_reg     <= `RST_UV_PCT;
            ov_pct_reg     <= `RST_OV_PCT;
            t1_reg         <= `RST_T1;
            cur_limit_reg  <= `RST_CUR_LIMIT;
            irq_status_reg <= 5'h0;
            irq_mask_reg   <= 5'h0;
            irq            <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                aw_have_reg <= 1'b1;
                awready     <= 1'b0;
                aw_idx_reg  <= (awaddr[1:0] == 2'h0) ? awaddr[5:2] : 4'hf;
            end
            if (wvalid && wready) begin
                w_have_reg <= 1'b1;
                wready     <= 1'b0;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg  <= 1'b0;
                bvalid      <= 1'b1;
                bresp       <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
                case (aw_idx_reg)
                    `OFS_CTRL:      ctrl_reg      <= wr_word[3:0];
                    `OFS_NOMINAL:   nominal_reg   <= wr_word[15:0];
                    `OFS_LOWER_PCT: lower_pct_reg <= wr_word[10:0];
                    `OFS_RAISE_PCT: raise_pct_reg <= wr_word[10:0];
                    `OFS_UV_PCT:    uv_pct_reg    <= wr_word[10:0];
                    `OFS_OV_PCT:    ov_pct_reg    <= wr_word[10:0];
                    `OFS_T1:        t1_reg        <= wr_word[7:0];
                    `OFS_CUR_LIMIT: cur_limit_reg <= wr_word[15:0];
                    `OFS_IRQ_MASK:  irq_mask_reg  <= wr_word[4:0];
                    default: begin
                    end
                endcase
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
            if (rd_take) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= reg_word(araddr[5:2]);
                rresp   <= (araddr[5:2] <= `OFS_VOLTAGE && araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
            // Read clears, but a new event in the same cycle stays set
            if (rd_take && araddr[5:2] == `OFS_IRQ_STATUS) begin
                irq_status_reg <= irq_set;
            end else begin
                irq_status_reg <= irq_status_reg | irq_set;
            end
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule

// File: dv/tap_relay_properties.sv
`timescale 1ns/100ps
// ------------------------------
// Lamp and relay properties
// ------------------------------
module tap_relay_props (
    // Clock and reset
    input wire aclk, aresetn,
    // Relays and their lamps
    input wire lower_relay, raise_relay, uv_relay, ov_relay, control_fail_relay,
    input wire lower_relay_lamp, raise_relay_lamp, uv_lamp, ov_lamp, control_fail_lamp, manual_lamp,
    // Unit and shed lamps
    input wire volts_lamp, kv_lamp, pct_lamp, sec_lamp, shed3_lamp, shed_three_pct_input
);
    // One domain, so clock and reset are stated once
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A lamp lagging its relay would mislead the operator, so no lag is allowed
    chk_lower_lamp: assert property (lower_relay_lamp == lower_relay) else $error("lower lamp");
    chk_raise_lamp: assert property (raise_relay_lamp == raise_relay) else $error("raise lamp");
    chk_uv_pair: assert property (uv_lamp == uv_relay) else $error("uv lamp");
    chk_ov_pair: assert property (ov_lamp == ov_relay) else $error("ov lamp");
    chk_cf_pair: assert property (control_fail_lamp == control_fail_relay) else $error("cf lamp");
    // Unit lamp lights one cycle after release
    chk_unit_single: assert property ($past(aresetn) |-> $onehot({volts_lamp, kv_lamp, pct_lamp, sec_lamp}))
        else $error("unit lamps");
    chk_shed_lag: assert property ($past(aresetn) |-> shed3_lamp == $past(shed_three_pct_input))
        else $error("shed lamp");
    chk_manual_quiet: assert property (manual_lamp && $past(manual_lamp) |-> !lower_relay && !raise_relay)
        else $error("manual pulse");
    chk_reset_quiet: assert property ($rose(aresetn) |-> !(lower_relay | raise_relay | uv_relay | ov_relay
        | control_fail_relay)) else $error("relay after reset");
    // Main scenarios
    cover property (uv_relay);
    cover property (ov_relay && lower_relay);
    cover property (control_fail_relay);
endmodule
bind tap_relay tap_relay_props u_props (.aclk(aclk), .aresetn(aresetn), .lower_relay(lower_relay),
    .raise_relay(raise_relay), .uv_relay(uv_relay), .ov_relay(ov_relay), .control_fail_relay(control_fail_relay),
    .lower_relay_lamp(lower_relay_lamp), .raise_relay_lamp(raise_relay_lamp), .uv_lamp(uv_lamp), .ov_lamp(ov_lamp),
    .control_fail_lamp(control_fail_lamp), .manual_lamp(manual_lamp), .volts_lamp(volts_lamp), .kv_lamp(kv_lamp),
    .pct_lamp(pct_lamp), .sec_lamp(sec_lamp), .shed3_lamp(shed3_lamp), .shed_three_pct_input(shed_three_pct_input));

// File: dv/grid_model.sv
`timescale 1ns/100ps
// ------------------------------
// Transformer side and shed contacts
// ------------------------------
module grid_model (
    input  wire        aclk,
    output reg  [15:0] meas_voltage,
    output reg         meas_valid,
    output reg  [15:0] meas_current,
    output reg         shed_three_pct_input, shed_six_pct_input, shed_nine_pct_input
);
    // Light load and open contacts at start
    initial begin
        {meas_voltage, meas_valid, meas_current} = 33'h0;
        {shed_nine_pct_input, shed_six_pct_input, shed_three_pct_input} = 3'h0;
    end
    // One sample, then a scrambled bus so a late capture shows
    task send(input [15:0] v);
        @(posedge aclk);
        meas_voltage <= v;
        meas_valid <= 1'b1;
        @(posedge aclk);
        meas_valid <= 1'b0;
        meas_voltage <= ~v;
        repeat (3) @(posedge aclk);
        #1;
    endtask
    // Contact stays closed until the next call
    task shed(input [2:0] s);
        @(posedge aclk);
        shed_three_pct_input <= s[0];
        shed_six_pct_input <= s[1];
        shed_nine_pct_input <= s[2];
    endtask
    // Load current seen by the overcurrent option
    task load(input [15:0] c);
        meas_current <= c;
    endtask
endmodule

// File: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] rs;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] meas_voltage, meas_current;
    wire meas_valid, shed_three_pct_input, shed_six_pct_input, shed_nine_pct_input, awready, wready, bvalid;
    wire arready, rvalid, irq, lower_relay, raise_relay, uv_relay, ov_relay, control_fail_relay;
    wire lower_presignal_lamp, raise_presignal_lamp, uv_lamp, ov_lamp, lower_relay_lamp, raise_relay_lamp;
    wire manual_lamp, control_fail_lamp, volts_lamp, kv_lamp, pct_lamp, sec_lamp, shed3_lamp, shed6_lamp, shed9_lamp;
    int failures = 0, check_count = 0, n;
    // Ten cycles per second keeps the five minute count short
    tap_relay #(.TICK_CYCLES(10)) dut (.*);
    grid_model grid (.*);
    always #5 aclk = ~aclk;
    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bus writes: each channel dropped at its own handshake
    task axw(input [5:0] a, input [31:0] d, input [3:0] s = 4'hf);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask
    task axr(input [5:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        {rd, rs} = {rdata, rresp};
    endtask
    task t_regs;
        @(posedge aclk);
        #1;
        check({lower_relay, raise_relay, uv_relay, ov_relay, control_fail_relay, uv_lamp, ov_lamp}, 0);
        axr(6'h04);
        check(rd, 32'h044c);
        axr(6'h30);
        check(rs, 2'h2);
        axw(6'h18, 32'h0, 4'he);
        check(rs, 2'h0);
        axr(6'h18);
        check(rd, 32'h1e);
    endtask
    task t_units;
        for (int u = 0; u < 4; u++) begin
            axw(6'h00, (u << 2) | 1);
            repeat (2) @(posedge aclk);
            #1;
            check({sec_lamp, pct_lamp, kv_lamp, volts_lamp}, 4'h1 << u);
            check(manual_lamp, 1'b1);
        end
        axw(6'h00, 32'h0);
        repeat (2) @(posedge aclk);
        #1;
        check(manual_lamp, 1'b0);
    endtask
    // Both sides of each presignal limit
    task t_presig;
        logic [15:0] v [4] = '{16'h0463, 16'h0462, 16'h0435, 16'h0436};
        logic [1:0] e [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
        for (int i = 0; i < 4; i++) begin
            grid.send(v[i]);
            check({lower_presignal_lamp, raise_presignal_lamp}, e[i]);
        end
    endtask
    // Lower limit under each shed step, then with the contact open again
    task t_shed;
        logic [15:0] lim [3] = '{16'h0440, 16'h041e, 16'h03fd};
        for (int i = 0; i < 3; i++) begin
            grid.shed(3'h1 << i);
            grid.send(lim[i] + 16'h1);
            check({shed9_lamp, shed6_lamp, shed3_lamp, lower_presignal_lamp}, {3'h1 << i, 1'b1});
            grid.send(lim[i]);
            check(lower_presignal_lamp, 1'b0);
            grid.shed(3'h0);
            grid.send(lim[i] + 16'h1);
            check(lower_presignal_lamp, 1'b0);
        end
    endtask
    task t_uv;
        axw(6'h28, 32'h1);
        grid.send(16'h036f);
        check({uv_relay, uv_lamp, irq}, 3'h7);
        axr(6'h24);
        check(rd[0], 1'b1);
        repeat (2) @(posedge aclk);
        #1;
        check(irq, 1'b0);
        grid.send(16'h03a7);
        check(uv_lamp, 1'b1);
        grid.send(16'h03a8);
        check(uv_lamp, 1'b0);
    endtask
    // High speed return: measure one on phase and one off phase
    task t_ov;
        grid.send(16'h04bb);
        check({ov_relay, ov_lamp}, 2'h3);
        for (n = 0; n < 500 && lower_relay; n++) @(posedge aclk);
        for (n = 0; n < 99 && !lower_relay; n++) @(posedge aclk);
        check(n, 20);
        for (n = 0; n < 99 && lower_relay; n++) @(posedge aclk);
        check(n, 20);
        grid.load(16'h05dd);
        axw(6'h00, 32'h2);
        axr(6'h20);
        check(rd[9:8], 2'h3);
        grid.send(16'h0483);
        check(ov_lamp, 1'b1);
        grid.send(16'h0482);
        check(ov_lamp, 1'b0);
    endtask
    task t_cf;
        grid.send(16'h044c);
        grid.send(16'h047e);
        repeat (2900) @(posedge aclk);
        check(control_fail_relay, 1'b0);
        for (n = 0; n < 300 && !control_fail_relay; n++) @(posedge aclk);
        #1;
        check(control_fail_lamp, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_units;
        t_presig;
        t_shed;
        t_uv;
        t_ov;
        t_cf;
        conclude;
    end
    // Whole run is near 3250 cycles
    initial begin
        #200000;
        failures++;
        conclude;
    end
endmodule
